//--- div_if.sv
// Carrier between the mapper and its shared divider.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface div_if;
  logic        start;
  logic [23:0] dividend;
  logic [7:0]  divisor;
  logic        busy;
  logic        done;
  logic [23:0] quotient;

  modport requester (output start, output dividend, output divisor,
                     input busy, input done, input quotient);
  modport engine    (input start, input dividend, input divisor,
                     output busy, output done, output quotient);
endinterface : div_if

//--- drive_profile_assembly_mapper.sv
// Drive profile assembly mapper: output/input assemblies to inverter.
// Assumes inverter words are sampled synchronously to clk and the
// register port master follows the one-cycle strobe protocol.
`timescale 1ns/10ps
module drive_profile_assembly_mapper
  import drive_profile_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        consume_timeout,
  input  wire logic [15:0] operation_status_word,
  input  wire logic [15:0] output_frequency,
  input  wire logic [7:0]  motor_pole_count,
  input  wire logic        pole_count_valid,
  input  wire logic [7:0]  drive_state,
  output logic      [15:0] operation_command_word,
  output logic      [15:0] frequency_command,
  output logic             frequency_command_write,
  output logic      [31:0] in_assembly,
  output logic             produce_active
);

  // Ready decode, shared by the flag and its check
  function automatic logic is_ready_state(input logic [7:0] s);
    is_ready_state = (s == DS_READY) || (s == DS_ENABLED) ||
                     (s == DS_STOPPING);
  endfunction : is_ready_state

  // Clamp a conversion result into the 16-bit speed field
  function automatic logic [15:0] sat16(input logic [23:0] v);
    sat16 = (v[23:16] != 8'h00) ? 16'hffff : v[15:0];
  endfunction : sat16

  div_if div_bus ();

  speed_divider u_div (
    .clk      (clk),
    .reset_n  (reset_n),
    .port_div (div_bus.engine)
  );

  logic        conn_open;
  logic        conn_inst21;
  logic        produce_stopped;
  logic [31:0] out_asm;
  logic        prev_fault_reset;
  logic [7:0]  pole_reg;
  logic        poles_latched;
  logic [15:0] speed_actual;
  seq_t        state;
  logic        div_start;
  logic [23:0] div_dividend;
  logic [7:0]  div_divisor;

  // Register port decode
  wire wr_conn = wr && (addr == OFS_CONN);
  wire wr_out  = wr && (addr == OFS_OUT_ASM);
  wire reopen  = wr_conn && wdata[CONN_OPEN] && !conn_open;

  // Output assembly fields; request bits 5 and 6 are never read
  wire        cmd_fwd     = out_asm[OUT_FWD];
  wire        cmd_rev     = out_asm[OUT_REV] && conn_inst21;
  wire        fault_reset = out_asm[OUT_FAULT_RESET];
  wire [15:0] speed_ref   = out_asm[OUT_SPEED_LSB +: 16];

  // Inverter status decode
  wire run_fwd  = operation_status_word[STS_FWD];
  wire run_rev  = operation_status_word[STS_REV];
  wire faulted  = operation_status_word[STS_ALM];
  wire ramping  = operation_status_word[STS_ACC] ||
                  operation_status_word[STS_DEC];
  wire up_speed = (run_fwd || run_rev) && !ramping;
  wire ready    = is_ready_state(drive_state);
  wire poles_ok = poles_latched && (pole_reg != 8'h00);

  // Input assembly byte 0 for each instance
  wire [7:0] byte0_70 = {5'h00, run_fwd, 1'b0, faulted};
  wire [7:0] byte0_71 = {up_speed, 1'b0, 1'b0, ready,
                         run_rev, run_fwd, 1'b0, faulted};
  wire [7:0] byte1    = conn_inst21 ? drive_state : 8'h00;
  wire [7:0] byte0    = conn_inst21 ? byte0_71 : byte0_70;
  wire       producing = conn_open && !produce_stopped;
  wire [31:0] next_in_assembly =
    producing ? {speed_actual, byte1, byte0} : 32'h00000000;

  // Next command word; reset fires only on the rising edge
  wire        rst_edge = fault_reset && !prev_fault_reset;
  wire [15:0] next_command =
    {rst_edge, 13'h0000, cmd_rev, cmd_fwd};

  // Divider operand products, sized to 24 bits
  wire [23:0] ref_product = {8'h00, speed_ref} * {16'h0000, pole_reg};
  wire [23:0] act_product = {8'h00, output_frequency} * RPM_HZ_FACTOR;

  // Read data mux; unmapped offsets read zero
  wire [31:0] status_word = {21'h000000, conn_inst21, producing,
                             poles_latched, pole_reg};
  wire [31:0] next_rdata =
    (addr == OFS_CONN)    ? {30'h00000000, conn_inst21, conn_open} :
    (addr == OFS_OUT_ASM) ? out_asm :
    (addr == OFS_IN_ASM)  ? in_assembly :
    (addr == OFS_STATUS)  ? status_word :
    (addr == OFS_CLASSES) ? {CLASS_AC_DRIVE, CLASS_SUPERVISOR,
                             CLASS_MOTOR_DATA, CLASS_ASSEMBLY} :
    32'h00000000;

  // Connection selection is the controller's choice of pair
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conn_open   <= 1'b0;
      conn_inst21 <= 1'b0;
    end else if (wr_conn) begin
      conn_open   <= wdata[CONN_OPEN];
      conn_inst21 <= wdata[CONN_INST21];
    end
  end

  // Timeout stops production until a new open; set beats clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      produce_stopped <= 1'b0;
    end else if (consume_timeout) begin
      produce_stopped <= 1'b1;
    end else if (reopen) begin
      produce_stopped <= 1'b0;
    end
  end

  // Output assembly storage, written as one word
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_asm <= 32'h00000000;
    end else if (wr_out) begin
      out_asm <= wdata;
    end
  end

  // Command word and edge history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_fault_reset       <= 1'b0;
      operation_command_word <= 16'h0000;
    end else begin
      prev_fault_reset       <= fault_reset;
      operation_command_word <= next_command;
    end
  end

  // Pole count caught once; later changes need a reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pole_reg      <= 8'h00;
      poles_latched <= 1'b0;
    end else if (pole_count_valid && !poles_latched) begin
      pole_reg      <= motor_pole_count;
      poles_latched <= 1'b1;
    end
  end

  // Conversion sequencer: reference then actual, round robin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state                   <= st_wait_poles;
      div_start               <= 1'b0;
      div_dividend            <= 24'h000000;
      div_divisor             <= 8'h00;
      frequency_command       <= 16'h0000;
      frequency_command_write <= 1'b0;
      speed_actual            <= 16'h0000;
    end else begin
      div_start               <= 1'b0;
      frequency_command_write <= 1'b0;
      case (state)
        st_wait_poles: begin
          if (poles_latched) begin
            state <= st_idle;
          end
        end
        st_idle: begin
          if (poles_ok) begin
            div_dividend <= ref_product;
            div_divisor  <= DIV_FACTOR;
            div_start    <= 1'b1;
            state        <= st_ref_div;
          end else begin
            // Zero poles would divide by zero; report stopped
            speed_actual <= 16'h0000;
          end
        end
        st_ref_div: begin
          if (div_bus.done) begin
            frequency_command       <= sat16(div_bus.quotient);
            frequency_command_write <= 1'b1;
            div_dividend            <= act_product;
            div_divisor             <= pole_reg;
            div_start               <= 1'b1;
            state                   <= st_act_div;
          end
        end
        st_act_div: begin
          if (div_bus.done) begin
            speed_actual <= sat16(div_bus.quotient);
            state        <= st_idle;
          end
        end
        default: begin
          state <= st_wait_poles;
        end
      endcase
    end
  end

  assign div_bus.start    = div_start;
  assign div_bus.dividend = div_dividend;
  assign div_bus.divisor  = div_divisor;

  // Produced data and read data, registered for the outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_assembly    <= 32'h00000000;
      produce_active <= 1'b0;
      rdata          <= 32'h00000000;
    end else begin
      in_assembly    <= next_in_assembly;
      produce_active <= producing;
      rdata          <= rd ? next_rdata : 32'h00000000;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_timeout;
    consume_timeout;
  endsequence

  sequence s_no_reopen;
    !wr_conn;
  endsequence

  sequence s_ref_start;
    state == st_idle && poles_ok;
  endsequence

  AST_FWD_COPY: assert property (
    wr_out |-> ##2 operation_command_word[CMD_FWD] == $past(wdata[0], 2))
    else $error("forward command not copied");

  AST_REV_BLOCK: assert property (
    !$past(conn_inst21) |-> !operation_command_word[CMD_REV])
    else $error("reverse driven on instance 20");

  AST_RST_EDGE: assert property (
    operation_command_word[CMD_RST] |->
      $past(out_asm[OUT_FAULT_RESET]) && !$past(prev_fault_reset))
    else $error("reset issued without rising edge");

  AST_RST_ONCE: assert property (
    operation_command_word[CMD_RST] |=> !operation_command_word[CMD_RST])
    else $error("reset held more than one cycle");

  AST_FAULT_COPY: assert property (
    $past(producing) |-> in_assembly[IN_FAULTED] ==
      $past(operation_status_word[STS_ALM]))
    else $error("faulted flag mismatch");

  AST_ZERO_FLAGS: assert property (
    !in_assembly[IN_WARNING] && !in_assembly[IN_CTRL_SRC] &&
    !in_assembly[IN_REF_SRC])
    else $error("unused flag not zero");

  AST_READY: assert property (
    $past(producing && conn_inst21) |->
      in_assembly[IN_READY] == is_ready_state($past(drive_state)))
    else $error("ready flag mismatch");

  AST_UP_TO_SPEED: assert property (
    in_assembly[IN_UP_TO_SPD] |->
      $past(run_fwd || run_rev) && !$past(ramping))
    else $error("up to speed while ramping or stopped");

  AST_STOP: assert property (
    s_timeout ##1 s_no_reopen |-> ##1 !produce_active && in_assembly == 0)
    else $error("production continued after timeout");

  AST_POLE_HOLD: assert property (
    $past(poles_latched) |-> $stable(pole_reg))
    else $error("pole count changed after latch");

  AST_CONV_TIME: assert property (
    s_ref_start |-> ##[26:28] frequency_command_write)
    else $error("frequency command not written in time");

  AST_WRITE_PULSE: assert property (
    frequency_command_write |=> !frequency_command_write)
    else $error("frequency write pulse longer than one cycle");

  AST_RUN_FWD: assert property (
    $past(producing) |-> in_assembly[IN_RUN_FWD] == $past(run_fwd))
    else $error("running forward flag mismatch");

  AST_RUN_REV: assert property (
    $past(producing && conn_inst21) |->
      in_assembly[IN_RUN_REV] == $past(run_rev))
    else $error("running reverse flag mismatch");

  AST_STATE_BYTE: assert property (
    $past(producing && conn_inst21) |->
      in_assembly[15:8] == $past(drive_state))
    else $error("supervisor state byte mismatch");

  AST_UP_SET: assert property (
    $past(producing && conn_inst21 && up_speed) |->
      in_assembly[IN_UP_TO_SPD])
    else $error("up to speed flag missing");

  AST_INST70_ZERO: assert property (
    $past(producing && !conn_inst21) |->
      in_assembly[15:3] == '0 && !in_assembly[IN_WARNING])
    else $error("unused instance 70 bits not zero");

endmodule : drive_profile_assembly_mapper

//--- drive_profile_pkg.sv
// Constants for the drive profile assembly mapper.
// Assumes a 100 MHz system clock and a 32-bit word register port.
package drive_profile_pkg;

  // Register byte offsets on the local port
  localparam logic [7:0] OFS_CONN    = 8'h00;
  localparam logic [7:0] OFS_OUT_ASM = 8'h04;
  localparam logic [7:0] OFS_IN_ASM  = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_CLASSES = 8'h10;

  // Connection control fields
  localparam int CONN_OPEN   = 0;
  localparam int CONN_INST21 = 1;

  // Output assembly byte 0 fields and speed reference LSB
  localparam int OUT_FWD          = 0;
  localparam int OUT_REV          = 1;
  localparam int OUT_FAULT_RESET  = 2;
  localparam int OUT_NETWORK_CONTROL_REQ   = 5;
  localparam int OUT_NETWORK_REFERENCE_REQ = 6;
  localparam int OUT_SPEED_LSB    = 16;

  // Input assembly byte 0 fields
  localparam int IN_FAULTED   = 0;
  localparam int IN_WARNING   = 1;
  localparam int IN_RUN_FWD   = 2;
  localparam int IN_RUN_REV   = 3;
  localparam int IN_READY     = 4;
  localparam int IN_CTRL_SRC  = 5;
  localparam int IN_REF_SRC   = 6;
  localparam int IN_UP_TO_SPD = 7;

  // Inverter command and status word bits
  localparam int CMD_FWD = 0;
  localparam int CMD_REV = 1;
  localparam int CMD_RST = 15;
  localparam int STS_FWD = 0;
  localparam int STS_REV = 1;
  localparam int STS_ACC = 9;
  localparam int STS_DEC = 10;
  localparam int STS_ALM = 11;

  // Status register fields
  localparam int STAT_POLES_LSB = 0;
  localparam int STAT_LATCHED   = 8;
  localparam int STAT_PRODUCING = 9;
  localparam int STAT_INST21    = 10;

  // Object class codes
  localparam logic [7:0] CLASS_ASSEMBLY   = 8'h04;
  localparam logic [7:0] CLASS_MOTOR_DATA = 8'h28;
  localparam logic [7:0] CLASS_SUPERVISOR = 8'h29;
  localparam logic [7:0] CLASS_AC_DRIVE   = 8'h2a;

  // Supervisor states that count as ready (plain defaults)
  localparam logic [7:0] DS_READY    = 8'h03;
  localparam logic [7:0] DS_ENABLED  = 8'h04;
  localparam logic [7:0] DS_STOPPING = 8'h05;

  // Conversion factor and divider size
  localparam logic [23:0] RPM_HZ_FACTOR = 24'h000078;
  localparam logic [7:0]  DIV_FACTOR    = 8'h78;
  localparam logic [4:0]  DIV_STEPS     = 5'h18;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    st_wait_poles,
    st_idle,
    st_ref_div,
    st_act_div
  } seq_t;

endpackage : drive_profile_pkg

//--- scanner_model.sv
// Scanner model: drives the mapper's register port as the I/O master.
// Assumes the mapper answers a read one cycle after the strobe.
`timescale 1ns/10ps
module scanner_model
  import drive_profile_pkg::*;
(
  input  wire logic        clk,
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  // Idle bus at time zero
  initial begin
    addr  = 8'hff;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // One-cycle write; data inverted after so stale values never match
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask : bus_write

  // One-cycle read; data taken only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_read

  // Close, then open on pair 21/71 or 20/70; reopen clears a timeout
  task automatic open_conn(input logic i21);
    bus_write(OFS_CONN, 32'h0);
    bus_write(OFS_CONN, {30'h0, i21, 1'b1});
  endtask : open_conn
endmodule : scanner_model

//--- speed_divider.sv
// Restoring divider shared by both speed conversions.
// Assumes start is a single-cycle pulse given only while idle.
`timescale 1ns/10ps
module speed_divider
  import drive_profile_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  div_if.engine    port_div
);

  logic [23:0] quo;
  logic [7:0]  rem;
  logic [7:0]  den;
  logic [4:0]  count;
  logic        busy;
  logic        done;
  wire  [8:0]  trial = {rem, quo[23]};
  wire         fits  = trial >= {1'b0, den};
  wire  [8:0]  diff  = trial - {1'b0, den};

  // One quotient bit per clock; result truncates
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quo   <= 24'h000000;
      rem   <= 8'h00;
      den   <= 8'h00;
      count <= 5'h00;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (port_div.start && !busy) begin
      quo   <= port_div.dividend;
      rem   <= 8'h00;
      den   <= port_div.divisor;
      count <= DIV_STEPS;
      busy  <= 1'b1;
      done  <= 1'b0;
    end else if (busy) begin
      quo   <= {quo[22:0], fits};
      rem   <= fits ? diff[7:0] : trial[7:0];
      count <= count - 5'h01;
      busy  <= (count != 5'h01);
      done  <= (count == 5'h01);
    end else begin
      done  <= 1'b0;
    end
  end

  assign port_div.busy     = busy;
  assign port_div.done     = done;
  assign port_div.quotient = quo;

endmodule : speed_divider

//--- tb_top.sv
// Testbench for the drive profile assembly mapper.
// Assumes the scanner model owns the register port; the bench plays
// the inverter and checks both assemblies and the command outputs.
`timescale 1ns/10ps
module tb_top
  import drive_profile_pkg::*;
;
  localparam logic [31:0] POLES = 32'h4;

  logic        clk;
  logic        reset_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        consume_timeout;
  logic [15:0] operation_status_word;
  logic [15:0] output_frequency;
  logic [7:0]  motor_pole_count;
  logic        pole_count_valid;
  logic [7:0]  drive_state;
  logic [15:0] operation_command_word;
  logic [15:0] frequency_command;
  logic        frequency_command_write;
  logic [31:0] in_assembly;
  logic        produce_active;
  int          err_total = 0;
  int          compares = 0;
  int          rst_pulses = 0;

  scanner_model scn (
    .clk   (clk),
    .addr  (addr),
    .wdata (wdata),
    .wr    (wr),
    .rd    (rd),
    .rdata (rdata)
  );

  drive_profile_assembly_mapper i_dut (
    .clk                     (clk),
    .reset_n                 (reset_n),
    .addr                    (addr),
    .wdata                   (wdata),
    .wr                      (wr),
    .rd                      (rd),
    .rdata                   (rdata),
    .consume_timeout         (consume_timeout),
    .operation_status_word   (operation_status_word),
    .output_frequency        (output_frequency),
    .motor_pole_count        (motor_pole_count),
    .pole_count_valid        (pole_count_valid),
    .drive_state             (drive_state),
    .operation_command_word  (operation_command_word),
    .frequency_command       (frequency_command),
    .frequency_command_write (frequency_command_write),
    .in_assembly             (in_assembly),
    .produce_active          (produce_active)
  );

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Count cycles with the reset bit up, to prove it is a single pulse
  always @(posedge clk) begin
    if (operation_command_word[15] === 1'b1) begin
      rst_pulses <= rst_pulses + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Step past edges so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Conversions clip rather than wrap
  function automatic logic [15:0] sat16(input logic [31:0] v);
    return (v > 32'hffff) ? 16'hffff : v[15:0];
  endfunction : sat16

  // Expected bytes 0 and 1 of the produced assembly
  function automatic logic [15:0] exp_lo(input logic [15:0] sw,
                                         input logic [7:0]  ds,
                                         input logic        i21);
    logic [7:0] b;
    b    = 8'h0;
    b[0] = sw[11];
    b[2] = sw[0];
    if (!i21) begin
      return {8'h0, b};
    end
    b[3] = sw[1];
    b[4] = (ds == DS_READY) || (ds == DS_ENABLED) || (ds == DS_STOPPING);
    b[7] = (sw[0] | sw[1]) & ~sw[9] & ~sw[10];
    return {ds, b};
  endfunction : exp_lo

  // Random command, speed and status mix for one instance pair
  task automatic run_mix(input logic i21);
    logic [31:0] d;
    logic [15:0] f;
    logic [15:0] e;
    int          n;
    for (int i = 0; i < 12; i++) begin
      d = $urandom & 32'hffff_0063;
      f = 16'($urandom & 32'h0fff);
      if (i == 0) begin
        d[31:16] = 16'hffff;
      end
      @(posedge clk);
      operation_status_word <= 16'($urandom);
      drive_state           <= (i < 6) ? 8'(i) : 8'($urandom);
      output_frequency      <= f;
      scn.bus_write(OFS_OUT_ASM, d);
      tick(150);
      n = 0;
      while (frequency_command_write !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      chk(n < 200, 1'b1);
      e = exp_lo(operation_status_word, drive_state, i21);
      chk(operation_command_word, {d[1] & i21, d[0]});
      chk(frequency_command, sat16(d[31:16] * POLES / 32'h78));
      chk(in_assembly[31:16], sat16(f * 32'h78 / POLES));
      chk(in_assembly[15:0], e);
    end
  endtask : run_mix

  // Main sequence
  initial begin : main
    logic [31:0] d;
    int          n;
    reset_n               = 1'b0;
    consume_timeout       = 1'b0;
    operation_status_word = 16'h0;
    output_frequency      = 16'h0;
    motor_pole_count      = 8'h0;
    pole_count_valid      = 1'b0;
    drive_state           = 8'h0;
    void'($urandom(29));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    tick(1);
    chk({operation_command_word, frequency_command}, 32'h0);
    chk(in_assembly, 32'h0);
    // Later pole change must not be taken
    @(posedge clk);
    motor_pole_count <= 8'h04;
    pole_count_valid <= 1'b1;
    repeat (2) @(posedge clk);
    motor_pole_count <= 8'h06;
    scn.bus_read(OFS_CLASSES, d);
    chk(d, 32'h2a292804);
    scn.bus_read(8'h40, d);
    chk(d, 32'h0);
    scn.open_conn(1'b1);
    scn.bus_read(OFS_STATUS, d);
    chk(d[10:0], 11'h704);
    run_mix(1'b1);
    // Reset only on a rising edge of the fault reset bit
    n = rst_pulses;
    scn.bus_write(OFS_OUT_ASM, 32'h4);
    tick(4);
    chk(rst_pulses - n, 32'h1);
    scn.bus_write(OFS_OUT_ASM, 32'h5);
    scn.bus_write(OFS_OUT_ASM, 32'h0);
    tick(4);
    chk(rst_pulses - n, 32'h1);
    scn.bus_write(OFS_OUT_ASM, 32'h4);
    tick(4);
    chk(rst_pulses - n, 32'h2);
    // Consumer timeout stops production until reopened
    @(posedge clk);
    consume_timeout <= 1'b1;
    @(posedge clk);
    consume_timeout <= 1'b0;
    tick(3);
    chk(produce_active, 1'b0);
    chk(in_assembly, 32'h0);
    scn.open_conn(1'b0);
    tick(2);
    chk(produce_active, 1'b1);
    run_mix(1'b0);
    wrap_up();
  end

  // Cut a hang short; the whole run needs about 4000 cycles
  initial begin : watchdog
    #(60000 * 10);
    err_total++;
    wrap_up();
  end
endmodule : tb_top
